//--- src/vcpsp_top.sv
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module vcpsp_top #(
    parameter int ADDR_W = 4,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // AXI4-Lite slave
    input logic [ADDR_W-1:0] s_axi_awaddr,
    input logic [2:0] s_axi_awprot,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [ADDR_W-1:0] s_axi_araddr,
    input logic [2:0] s_axi_arprot,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    // Serial port
    input logic mclk,
    input logic frame_sync,
    input logic serial_rx_data,
    output logic serial_tx_data,
    output logic serial_tx_data_oe,
    // Mode and mute pins
    input logic linear_select_n,
    input logic tx_mute,
    input logic rx_mute
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || ADDR_W < 4) begin
        $error("vcpsp_top needs DEPTH >= 2 and ADDR_W >= 4");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt, ctrl_r, ctrl_nxt;
    logic rx_rdy_r, rx_rdy_nxt, under_r, under_nxt, frerr_r, frerr_nxt;
    logic lin_r, lin_nxt, seen_r, seen_nxt, mclk_prev_r, mclk_prev_nxt;
    vcpsp_pkg::vcpsp_rx_word_t rx_word_r, rx_word_nxt;
    vcpsp_pkg::vcpsp_state_t state_r, state_nxt;
    logic [11:0] idle_r, idle_nxt;
    logic [8:0] falls_r, falls_nxt;
    logic [4:0] slot_r, slot_nxt, tx_len_r, tx_len_nxt, rx_len_r, rx_len_nxt;
    logic [12:0] tx_sh_r, tx_sh_nxt;
    logic [15:0] rx_sh_r, rx_sh_nxt;
    logic txd_r, txd_nxt, txoe_r, txoe_nxt;
    logic [12:0] mem_r [DEPTH];
    logic [12:0] mem_nxt [DEPTH];
    logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;

    function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
        logic [3:0] w;
        w = {a[3:2], 2'b00};
        if ((a >> 4) != '0) begin
            return 3'h0;
        end
        return {1'b1, w[3:2]};
    endfunction

    assign s_axi_awready = !aw_full_r;
    assign s_axi_wready = !w_full_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign serial_tx_data = txd_r;
    assign serial_tx_data_oe = txoe_r;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [2:0] wsel, rsel;
        logic wr_go, is_tx, buf_rdy, push, pop, rise, fall, lost, lin_now;
        logic [12:0] smp;
        logic [31:0] st;
        wsel = reg_sel(awaddr_r);
        rsel = reg_sel(s_axi_araddr);
        wr_go = aw_full_r && w_full_r && !bvalid_r;
        is_tx = wsel == {1'b1, vcpsp_pkg::REG_TX_DATA[3:2]};
        buf_rdy = cnt_r < CW'(DEPTH);
        st = 32'h0000_0000;
        awaddr_nxt = awaddr_r;
        aw_full_nxt = aw_full_r;
        w_full_nxt = w_full_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        ctrl_nxt = ctrl_r;
        rx_rdy_nxt = rx_rdy_r;
        under_nxt = under_r;
        frerr_nxt = frerr_r;
        lin_nxt = lin_r;
        seen_nxt = seen_r;
        rx_word_nxt = rx_word_r;
        state_nxt = state_r;
        slot_nxt = slot_r;
        tx_len_nxt = tx_len_r;
        rx_len_nxt = rx_len_r;
        tx_sh_nxt = tx_sh_r;
        rx_sh_nxt = rx_sh_r;
        txd_nxt = txd_r;
        txoe_nxt = txoe_r;
        mem_nxt = mem_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        push = 1'b0;
        pop = 1'b0;
        smp = 13'h0000;
        rise = mclk && !mclk_prev_r;
        fall = !mclk && mclk_prev_r;
        mclk_prev_nxt = mclk;
        lost = (idle_r == vcpsp_pkg::PD_TIMEOUT_CYC);
        lin_now = !linear_select_n;
        // Write channel: address and data are taken in either order.
        if (s_axi_awvalid && !aw_full_r) begin
            aw_full_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_full_r) begin
            w_full_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        // A full buffer holds the write response back, stalling software.
        if (wr_go && (!is_tx || buf_rdy)) begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = wsel[2] ? vcpsp_pkg::RESP_OKAY
                                : vcpsp_pkg::RESP_SLVERR;
            push = is_tx;
            if (wsel == {1'b1, vcpsp_pkg::REG_CTRL[3:2]} && wstrb_r[0]) begin
                ctrl_nxt[7:0] = wdata_r[7:0];
            end
            if (wsel == {1'b1, vcpsp_pkg::REG_STATUS[3:2]} && wstrb_r[0]) begin
                if (wdata_r[vcpsp_pkg::ST_RX_RDY_BIT]) rx_rdy_nxt = 1'b0;
                if (wdata_r[vcpsp_pkg::ST_UNDER_BIT]) under_nxt = 1'b0;
                if (wdata_r[vcpsp_pkg::ST_FRERR_BIT]) frerr_nxt = 1'b0;
            end
        end
        // Read channel.
        st[vcpsp_pkg::ST_RX_RDY_BIT] = rx_rdy_r;
        st[vcpsp_pkg::ST_UNDER_BIT] = under_r;
        st[vcpsp_pkg::ST_PD_BIT] = state_r == vcpsp_pkg::LS_POWERDN;
        st[vcpsp_pkg::ST_LIN_BIT] = lin_now;
        st[vcpsp_pkg::ST_FRERR_BIT] = frerr_r;
        st[vcpsp_pkg::ST_LEVEL_LSB +: 8] = 8'(cnt_r);
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = rsel[2] ? vcpsp_pkg::RESP_OKAY
                                : vcpsp_pkg::RESP_SLVERR;
            case (rsel)
                {1'b1, vcpsp_pkg::REG_CTRL[3:2]}: rdata_nxt = ctrl_r;
                {1'b1, vcpsp_pkg::REG_STATUS[3:2]}: rdata_nxt = st;
                {1'b1, vcpsp_pkg::REG_RX_DATA[3:2]}: begin
                    rdata_nxt = 32'h0000_0000;
                    rdata_nxt[12:0] = rx_word_r.sample;
                    rdata_nxt[vcpsp_pkg::RX_VOL_LSB +: 3] = rx_word_r.volume;
                    rdata_nxt[vcpsp_pkg::RX_GAIN_LSB +: 8] =
                        vcpsp_pkg::gain_db(rx_word_r.volume, lin_r);
                end
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
        // Clock watchdog.
        idle_nxt = (rise || fall) ? 12'h000
                 : (lost ? idle_r : idle_r + 12'h001);
        // Frame length check, counted in falling edges between syncs.
        falls_nxt = (fall && falls_r != 9'h1FF) ? falls_r + 9'h001 : falls_r;
        if (fall && frame_sync) begin
            falls_nxt = 9'h000;
            seen_nxt = 1'b1;
            if (seen_r && falls_r != 9'(vcpsp_pkg::FRAME_MCLKS - 1)) begin
                frerr_nxt = 1'b1;
            end
        end
        // Serial link.
        case (state_r)
            vcpsp_pkg::LS_SHIFT: begin
                if (rise && slot_r < rx_len_r) begin
                    slot_nxt = slot_r + 5'h01;
                    if (slot_r < tx_len_r) begin
                        txd_nxt = tx_sh_r[12];
                        tx_sh_nxt = {tx_sh_r[11:0], 1'b0};
                        txoe_nxt = 1'b1;
                    end
                end
                if (fall && slot_r != 5'h00) begin
                    rx_sh_nxt = {rx_sh_r[14:0], serial_rx_data};
                    if (slot_r == tx_len_r) begin
                        txoe_nxt = 1'b0;
                    end
                    if (slot_r == rx_len_r) begin
                        state_nxt = vcpsp_pkg::LS_IDLE;
                        rx_rdy_nxt = 1'b1;
                        if (lin_r) begin
                            rx_word_nxt.sample = rx_sh_r[14:2];
                            rx_word_nxt.volume =
                                {rx_sh_r[1:0], serial_rx_data};
                        end else begin
                            rx_word_nxt.sample =
                                {5'h00, rx_sh_r[6:0], serial_rx_data};
                            rx_word_nxt.volume = 3'h0;
                        end
                        if (rx_mute) begin
                            rx_word_nxt.sample = lin_r ? 13'h0000
                                : {5'h00, vcpsp_pkg::MULAW_SILENCE};
                        end
                    end
                end
                // Power-down waits for a transmit word in flight to finish; a received word is not waited for.
                if (lost && !txoe_r) begin
                    state_nxt = vcpsp_pkg::LS_POWERDN;
                end
            end
            vcpsp_pkg::LS_POWERDN: begin
                txoe_nxt = 1'b0;
                if (rise || fall) begin
                    state_nxt = vcpsp_pkg::LS_IDLE;
                end
            end
            default: begin
                txoe_nxt = 1'b0;
                if (lost) begin
                    state_nxt = vcpsp_pkg::LS_POWERDN;
                end
            end
        endcase
        // A sync on a falling edge starts a frame and loads the word.
        if (fall && frame_sync && ctrl_r[vcpsp_pkg::CTRL_EN_BIT]
            && !(state_r == vcpsp_pkg::LS_SHIFT && txoe_r)) begin
            state_nxt = vcpsp_pkg::LS_SHIFT;
            slot_nxt = 5'h00;
            lin_nxt = lin_now;
            tx_len_nxt = lin_now ? vcpsp_pkg::LIN_SLOTS
                                 : vcpsp_pkg::CMP_SLOTS;
            rx_len_nxt = lin_now ? vcpsp_pkg::RX_LIN_SLOTS
                                 : vcpsp_pkg::CMP_SLOTS;
            pop = cnt_r != '0;
            under_nxt = under_nxt || !pop;
            smp = (pop && !tx_mute) ? mem_r[rp_r] : 13'h0000;
            tx_sh_nxt = lin_now ? smp
                : {vcpsp_pkg::mulaw_encode(smp), 5'h00};
        end
        // Transmit buffer of DEPTH entries (two by default).
        if (push) begin
            mem_nxt[wp_r] = wdata_r[12:0];
            wp_nxt = (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
        end
        if (pop) begin
            rp_nxt = (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
        end
        cnt_nxt = cnt_r + CW'(push) - CW'(pop);
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_r <= '0;
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= vcpsp_pkg::RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= vcpsp_pkg::RESP_OKAY;
            rdata_r <= 32'h0000_0000;
            ctrl_r <= vcpsp_pkg::CTRL_RESET;
            rx_rdy_r <= 1'b0;
            under_r <= 1'b0;
            frerr_r <= 1'b0;
            lin_r <= 1'b0;
            seen_r <= 1'b0;
            mclk_prev_r <= 1'b0;
            rx_word_r <= '0;
            state_r <= vcpsp_pkg::LS_IDLE;
            idle_r <= 12'h000;
            falls_r <= 9'h000;
            slot_r <= 5'h00;
            tx_len_r <= vcpsp_pkg::CMP_SLOTS;
            rx_len_r <= vcpsp_pkg::CMP_SLOTS;
            tx_sh_r <= 13'h0000;
            rx_sh_r <= 16'h0000;
            txd_r <= 1'b0;
            txoe_r <= 1'b0;
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            awaddr_r <= awaddr_nxt;
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            ctrl_r <= ctrl_nxt;
            rx_rdy_r <= rx_rdy_nxt;
            under_r <= under_nxt;
            frerr_r <= frerr_nxt;
            lin_r <= lin_nxt;
            seen_r <= seen_nxt;
            mclk_prev_r <= mclk_prev_nxt;
            rx_word_r <= rx_word_nxt;
            state_r <= state_nxt;
            idle_r <= idle_nxt;
            falls_r <= falls_nxt;
            slot_r <= slot_nxt;
            tx_len_r <= tx_len_nxt;
            rx_len_r <= rx_len_nxt;
            tx_sh_r <= tx_sh_nxt;
            rx_sh_r <= rx_sh_nxt;
            txd_r <= txd_nxt;
            txoe_r <= txoe_nxt;
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Buffer words need no reset; they are only read when counted valid.
    always_ff @(posedge aclk) begin
        mem_r <= mem_nxt;
    end

endmodule

//--- src/vcpsp_pkg.sv
package vcpsp_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int FRAME_MCLKS = 256;
    localparam int RESET_MIN_NS = 500;
    localparam int RESET_MIN_CYC = (RESET_MIN_NS * (CLK_HZ / 1_000_000)
                                    + 999) / 1000;
    localparam int PD_TIMEOUT_NS = 10_000;
    localparam logic [11:0] PD_TIMEOUT_CYC =
        12'(PD_TIMEOUT_NS * (CLK_HZ / 1_000_000) / 1000);

    // ----------------------------------------------------------------
    // Register map and fields
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_TX_DATA = 4'h8;
    localparam logic [3:0] REG_RX_DATA = 4'hC;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam int CTRL_EN_BIT = 0;
    localparam int ST_RX_RDY_BIT = 0;
    localparam int ST_UNDER_BIT = 1;
    localparam int ST_PD_BIT = 2;
    localparam int ST_LIN_BIT = 3;
    localparam int ST_FRERR_BIT = 4;
    localparam int ST_LEVEL_LSB = 8;
    localparam int RX_VOL_LSB = 16;
    localparam int RX_GAIN_LSB = 24;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Word formats
    // ----------------------------------------------------------------
    localparam logic [4:0] LIN_SLOTS = 5'h0D;
    localparam logic [4:0] CMP_SLOTS = 5'h08;
    localparam logic [4:0] RX_LIN_SLOTS = 5'h10;
    localparam logic [7:0] MULAW_SILENCE = 8'hFF;
    localparam logic [13:0] MULAW_BIAS = 14'h0021;
    localparam logic [13:0] MULAW_CLIP = 14'h1FDE;
    localparam int GAIN_TOP_DB = 3;
    localparam int GAIN_STEP_DB = 3;

    typedef struct packed {
        logic [2:0] volume;
        logic [12:0] sample;
    } vcpsp_rx_word_t;

    typedef enum logic [1:0] {
        LS_IDLE,
        LS_SHIFT,
        LS_POWERDN
    } vcpsp_state_t;

    // Sign-magnitude on a doubled scale so 13-bit samples use the 14-bit law.
    function automatic logic [7:0] mulaw_encode(input logic [12:0] s);
        logic [12:0] abs_v;
        logic [13:0] mag;
        logic [13:0] tmp;
        logic [2:0] seg;
        abs_v = s[12] ? (~s + 13'h0001) : s;
        mag = {abs_v, 1'b0};
        if (mag > MULAW_CLIP) begin
            mag = MULAW_CLIP;
        end
        mag = mag + MULAW_BIAS;
        seg = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (mag[i + 5]) begin
                seg = 3'(i);
            end
        end
        tmp = mag >> (int'(seg) + 1);
        return ~{s[12], seg, tmp[3:0]};
    endfunction

    function automatic logic [7:0] gain_db(input logic [2:0] vol,
                                           input logic lin);
        return lin ? 8'(GAIN_TOP_DB - GAIN_STEP_DB * int'(vol)) : 8'h00;
    endfunction

endpackage

//--- tb/vcpsp_top_chk.sv
`timescale 1ns/1ps
module vcpsp_top_chk (
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // Bus handshakes
    input logic s_axi_awready,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic [31:0] s_axi_rdata,
    // Serial port
    input logic mclk,
    input logic serial_tx_data,
    input logic serial_tx_data_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----
    // Rises seen while driving; the first slot's rise precedes enable.
    // ----
    logic mclk_d_r, mclk_d_nxt;
    logic [4:0] rise_r, rise_nxt;
    always_comb begin
        mclk_d_nxt = mclk;
        rise_nxt = 5'h00;
        if (serial_tx_data_oe) begin
            rise_nxt = rise_r + 5'((mclk && !mclk_d_r) ? 1 : 0);
        end
    end
    always_ff @(posedge aclk) begin
        mclk_d_r <= mclk_d_nxt;
        rise_r <= rise_nxt;
    end
    chk_oe_on_rise: assert property (
        $rose(serial_tx_data_oe) |-> $past(mclk))
        else $error("tx enable rose away from a clock rise");
    chk_bit_on_rise: assert property (
        serial_tx_data_oe && $past(serial_tx_data_oe)
        && $changed(serial_tx_data) |-> $past(mclk))
        else $error("tx bit changed away from a clock rise");
    chk_oe_off_fall: assert property (
        $fell(serial_tx_data_oe) |-> !$past(mclk))
        else $error("tx enable dropped away from a clock fall");
    chk_word_slots: assert property (
        $fell(serial_tx_data_oe) |-> rise_r == 5'h0C || rise_r == 5'h07)
        else $error("tx word has wrong slot count");
    chk_oe_min_hold: assert property (
        $rose(serial_tx_data_oe) |-> serial_tx_data_oe [*8])
        else $error("tx enable too short");
    chk_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    chk_rd_latency: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer not held");
    chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer not held");
    chk_wr_release: assert property (
        $rose(s_axi_bvalid) |-> s_axi_awready && s_axi_wready)
        else $error("write channels not released with the answer");
    cover property ($fell(serial_tx_data_oe) && rise_r == 5'h0C);
    cover property ($fell(serial_tx_data_oe) && rise_r == 5'h07);
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind vcpsp_top vcpsp_top_chk vcpsp_top_chk_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .mclk(mclk),
    .serial_tx_data(serial_tx_data),
    .serial_tx_data_oe(serial_tx_data_oe));

//--- tb/vcpsp_host_model.sv
`timescale 1ns/1ps
module vcpsp_host_model (
    // Bench control
    input logic aclk,
    input logic run,
    input logic lin,
    input logic [15:0] rx_word,
    // Serial port
    output logic mclk,
    output logic frame_sync,
    output logic serial_rx_data,
    input logic tx_o,
    input logic tx_oe,
    // Captured word and frame marker
    output logic [20:0] tx_res,
    output logic tx_done,
    output logic mid_frame
);
    // Eight bus clocks per period; it stops only when the bench asks.
    logic [2:0] div_r = 3'h0;
    logic [7:0] per_r = 8'h00;
    logic [15:0] sh_r = 16'h0000;
    logic [4:0] bits_r = 5'h00;
    logic oe_d_r = 1'b0;
    assign mclk = !div_r[2];
    assign frame_sync = per_r == 8'h00;
    // Idle slots toggle so a stale bit cannot pass for a real one.
    assign serial_rx_data = (per_r != 8'h00 && per_r <= (lin ? 16 : 8))
        ? rx_word[16 - int'(per_r)] : div_r[0];
    assign tx_done = oe_d_r && !tx_oe;
    assign tx_res = {bits_r, sh_r};
    assign mid_frame = run && per_r == 8'h80 && div_r == 3'h0;
    always_ff @(posedge aclk) begin
        oe_d_r <= tx_oe;
        if (run) begin
            div_r <= div_r + 3'h1;
            if (div_r == 3'h7) per_r <= per_r + 8'h01;
            if (div_r == 3'h3 && tx_oe) begin
                sh_r <= {sh_r[14:0], tx_o};
                bits_r <= bits_r + 5'h01;
            end
        end
        if (tx_done) begin
            sh_r <= 16'h0000;
            bits_r <= 5'h00;
        end
    end
endmodule

//--- tb/vcpsp_top_tb.sv
`timescale 1ns/1ps
module vcpsp_top_tb;
    logic aclk, aresetn, run, mclk, frame_sync, serial_rx_data;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, tx_o, tx_oe, tx_done, mid_frame;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic linear_select_n, tx_mute, rx_mute;
    logic [15:0] rx_word;
    logic [20:0] tx_res;
    logic [65:0] q_rd[$];
    logic [1:0] q_b[$];
    logic [20:0] q_tx[$];
    logic [65:0] e;
    logic [12:0] smp;
    logic [7:0] rc;
    logic [12:0] bw[3];
    logic [12:0] cs[3] = '{13'h0000, 13'h0FFF, 13'h1FFF};
    logic [7:0] ce[3] = '{8'hFF, 8'h80, 8'h7E};
    int errors, tests_run, cycles;
    integer seed;

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    vcpsp_top #(.ADDR_W(5)) vcpsp_top_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .mclk(mclk), .frame_sync(frame_sync),
        .serial_rx_data(serial_rx_data), .serial_tx_data(tx_o),
        .serial_tx_data_oe(tx_oe), .linear_select_n(linear_select_n),
        .tx_mute(tx_mute), .rx_mute(rx_mute));

    vcpsp_host_model vcpsp_host_model_i (
        .aclk(aclk), .run(run), .lin(!linear_select_n), .rx_word(rx_word),
        .mclk(mclk), .frame_sync(frame_sync),
        .serial_rx_data(serial_rx_data), .tx_o(tx_o), .tx_oe(tx_oe),
        .tx_res(tx_res), .tx_done(tx_done), .mid_frame(mid_frame));

    task automatic cmp(string name, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Ready for the answer rises with the request and is then left high.
    task automatic wr(logic [4:0] a, logic [31:0] d, logic [1:0] r);
        q_b.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
    endtask

    task automatic rd(logic [4:0] a, logic [31:0] d, logic [1:0] r,
                      logic [31:0] m);
        q_rd.push_back({m, r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
    endtask

    // One enabled frame; called in the second half of a frame.
    task automatic frame(logic ln, logic [12:0] s, logic [15:0] rw,
                         logic [20:0] et, logic [31:0] er, logic [31:0] m);
        linear_select_n <= ln;
        rx_word <= rw;
        wr(5'h08, {19'h0, s}, 2'h0);
        wr(5'h00, 32'h1, 2'h0);
        q_tx.push_back(et);
        @(posedge aclk iff mid_frame);
        wr(5'h00, 32'h0, 2'h0);
        rd(5'h0C, er, 2'h0, m);
    endtask

    always @(posedge aclk) begin
        cycles++;
        if (s_axi_bvalid && s_axi_bready) begin
            cmp("bresp", q_b.pop_front(), s_axi_bresp);
        end
        if (s_axi_rvalid && s_axi_rready) begin
            e = q_rd.pop_front();
            cmp("rresp", e[33:32], s_axi_rresp);
            cmp("rdata", e[31:0], s_axi_rdata & e[65:34]);
        end
        if (tx_done) cmp("tx word", q_tx.pop_front(), tx_res);
        if (cycles > 80000) begin
            errors++;
            end_sim();
        end
    end

    initial begin
        seed = 32'h9bba1414;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, tx_mute, rx_mute} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h0;
        {linear_select_n, rx_word, run, cycles} = {17'h0, 1'b1, 32'h0};
        {errors, tests_run} = 64'h0;
        repeat (13) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(5'h00, 32'h1, 2'h0, 32'hFFFFFFFF);
        wr(5'h00, 32'h0, 2'h0);
        wr(5'h14, 32'h1, 2'h2);
        rd(5'h14, 32'h0, 2'h2, 32'hFFFFFFFF);
        @(posedge aclk iff mid_frame);
        for (int v = 0; v < 8; v++) begin
            smp = 13'($random(seed));
            frame(1'b0, smp, {smp, 3'(v)}, {5'd13, 3'h0, smp},
                {8'(3 - 3 * v), 5'h0, 3'(v), 3'h0, smp},
                32'hFF071FFF);
        end
        foreach (cs[i]) begin
            rc = 8'($random(seed));
            frame(1'b1, cs[i], {rc, 8'h00}, {5'd8, 8'h00, ce[i]},
                {24'h0, rc}, 32'hFF0000FF);
        end
        tx_mute <= 1'b1;
        rx_mute <= 1'b1;
        frame(1'b0, 13'h0ABC, 16'hFFF8, {5'd13, 16'h0},
            32'h0, 32'h00001FFF);
        tx_mute <= 1'b0;
        rx_mute <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            bw[i] = 13'($random(seed));
            q_tx.push_back({5'd13, 3'h0, bw[i]});
        end
        q_tx.push_back({5'd13, 16'h0});
        wr(5'h08, {19'h0, bw[0]}, 2'h0);
        wr(5'h08, {19'h0, bw[1]}, 2'h0);
        rd(5'h04, 32'h200, 2'h0, 32'hFF00);
        wr(5'h00, 32'h1, 2'h0);
        wr(5'h08, {19'h0, bw[2]}, 2'h0);
        repeat (4) @(posedge aclk iff mid_frame);
        wr(5'h00, 32'h0, 2'h0);
        rd(5'h04, 32'h2, 2'h0, 32'h12);
        smp = 13'($random(seed));
        q_tx.push_back({5'd13, 3'h0, smp});
        wr(5'h08, {19'h0, smp}, 2'h0);
        wr(5'h00, 32'h1, 2'h0);
        @(posedge aclk iff tx_oe);
        repeat (20) @(posedge aclk);
        run <= 1'b0;
        repeat (300) @(posedge aclk);
        cmp("tx enable held", 32'h1, tx_oe);
        run <= 1'b1;
        @(posedge aclk iff mid_frame);
        wr(5'h00, 32'h0, 2'h0);
        run <= 1'b0;
        repeat (300) @(posedge aclk);
        cmp("tx enable off", 32'h0, tx_oe);
        rd(5'h04, 32'h4, 2'h0, 32'h4);
        run <= 1'b1;
        repeat (4) @(posedge aclk);
        end_sim();
    end
endmodule
